/* hdl/uic_top.sv */
// uic_top: axi4-lite slice for uart interrupts, fifo thresholds and parity
`timescale 1ns/1ps
module uic_top
    import uic_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)
(
    // clock and reset
    input logic sys_clk,
    input logic sys_rst,
    // axi4-lite write channels
    input logic [AW-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [DW-1:0] s_axi_wdata,
    input logic [DW/8-1:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    // axi4-lite read channels
    input logic [AW-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    // characters to the serializer
    output logic [CW-1:0] tx_char,
    output logic tx_par,
    output logic tx_par_en,
    output logic tx_valid,
    input logic tx_ready,
    // characters and events from the deserializer
    input logic rx_valid,
    input logic [CW-1:0] rx_char,
    input logic rx_par,
    input logic rx_break,
    input logic rx_frame_err,
    input logic rx_timeout,
    // interrupt
    output logic irq
);
    localparam int LW = $clog2(DEPTH) + 1;

    function automatic logic [LW-1:0] thr_level(input logic [THR_W-1:0] sel);
        case (sel)
            tx_thresh_one_eighth: thr_level = LW'(DEPTH / 8);
            tx_thresh_two_eighths: thr_level = LW'(DEPTH / 4);
            tx_thresh_six_eighths: thr_level = LW'((3 * DEPTH) / 4);
            tx_thresh_seven_eighths: thr_level = LW'((7 * DEPTH) / 8);
            default: thr_level = LW'(DEPTH / 2);
        endcase
    endfunction

    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------
    logic [AW-1:0] aw_addr;
    logic [DW-1:0] wd;
    logic lane0;
    logic [THR_W-1:0] tx_thr;
    logic [THR_W-1:0] rx_thr;
    logic [PAR_W-1:0] par_mode;
    logic [NIRQ-1:0] ien;
    logic [NIRQ-1:0] raw;
    logic [LW-1:0] tx_lvl_q;
    logic [LW-1:0] rx_lvl_q;
    logic tx_par_bit;
    logic par_en;
    logic par_err;

    uic_fifo_if #(.W(CW), .LW(LW)) txf();
    uic_fifo_if #(.W(CW), .LW(LW)) rxf();

    uic_fifo #(.W(CW), .DEPTH(DEPTH), .LW(LW)) u_txf (
        .clk(sys_clk),
        .rst(sys_rst),
        .f(txf)
    );
    uic_fifo #(.W(CW), .DEPTH(DEPTH), .LW(LW)) u_rxf (
        .clk(sys_clk),
        .rst(sys_rst),
        .f(rxf)
    );
    uic_parity u_par (
        .mode(par_mode),
        .tx_data(txf.rdata),
        .tx_bit(tx_par_bit),
        .par_en(par_en),
        .rx_data(rx_char),
        .rx_bit(rx_par),
        .rx_err(par_err)
    );

    //------------------------------------------------------------------
    // write decode
    //------------------------------------------------------------------
    // address and data are latched in either order; the write acts once both are held
    wire do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire wr_on = do_wr && lane0;
    wire wr_data = wr_on && (aw_addr == REG_DATA);
    wire wr_thr = wr_on && (aw_addr == REG_THRESH);
    wire wr_par = wr_on && (aw_addr == REG_PARITY);
    wire wr_ien_set = wr_on && (aw_addr == REG_IEN_SET);
    wire wr_ien_clr = wr_on && (aw_addr == REG_IEN_CLR);
    wire wr_iclr = wr_on && (aw_addr == REG_ICLR);
    wire wr_map = (aw_addr inside {REG_DATA, REG_FLAGS, REG_THRESH, REG_PARITY,
        REG_IEN_SET, REG_IEN_CLR, REG_RAW, REG_MASKED, REG_ICLR});
    wire [THR_W-1:0] wd_tx_thr = wd[THR_W-1:0];
    wire [THR_W-1:0] wd_rx_thr = wd[THR_RX_LSB +: THR_W];
    wire [NIRQ-1:0] wd_irq = wd[NIRQ-1:0];

    //------------------------------------------------------------------
    // read decode
    //------------------------------------------------------------------
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire rd_pop = rd_fire && (s_axi_araddr == REG_DATA);
    wire rd_masked = rd_fire && (s_axi_araddr == REG_MASKED);
    wire [NIRQ-1:0] masked = raw & ien;
    wire [1:0] flags = {!rxf.empty, !txf.full};
    wire [DW-1:0] rd_mux =
        (s_axi_araddr == REG_DATA) ? DW'(rxf.empty ? '0 : rxf.rdata) :
        (s_axi_araddr == REG_FLAGS) ? DW'(flags) :
        (s_axi_araddr == REG_THRESH) ? DW'({rx_thr, tx_thr}) :
        (s_axi_araddr == REG_PARITY) ? DW'(par_mode) :
        (s_axi_araddr == REG_IEN_SET) ? DW'(ien) :
        (s_axi_araddr == REG_RAW) ? DW'(raw) :
        (s_axi_araddr == REG_MASKED) ? DW'(masked) : '0;
    wire rd_map = (s_axi_araddr inside {REG_DATA, REG_FLAGS, REG_THRESH, REG_PARITY,
        REG_IEN_SET, REG_RAW, REG_MASKED});

    //------------------------------------------------------------------
    // fifo traffic and thresholds
    //------------------------------------------------------------------
    // writes to a full tx fifo are lost; software polls the space flag first
    wire tx_pop = !txf.empty && (!tx_valid || tx_ready);
    assign txf.push = wr_data;
    assign txf.wdata = wd[CW-1:0];
    assign txf.pop = tx_pop;
    assign rxf.push = rx_valid;
    assign rxf.wdata = rx_char;
    assign rxf.pop = rd_pop;
    wire [LW-1:0] tx_thr_lvl = thr_level(tx_thr);
    wire [LW-1:0] rx_thr_lvl = thr_level(rx_thr);
    wire tx_cross = (tx_lvl_q > tx_thr_lvl) && (txf.level <= tx_thr_lvl);
    wire rx_cross = (rx_lvl_q < rx_thr_lvl) && (rxf.level >= rx_thr_lvl);
    wire overrun = rx_valid && rxf.full;

    //------------------------------------------------------------------
    // interrupt status
    //------------------------------------------------------------------
    logic [NIRQ-1:0] set_vec;
    assign set_vec[irq_receive] = rx_cross;
    assign set_vec[irq_transmit] = tx_cross;
    assign set_vec[irq_receive_timeout] = rx_timeout;
    assign set_vec[irq_framing_error] = rx_frame_err;
    assign set_vec[irq_parity_error] = rx_valid && par_err;
    assign set_vec[irq_break_error] = rx_break;
    assign set_vec[irq_overrun] = overrun;
    // reading the masked view also acknowledges what it showed
    wire [NIRQ-1:0] clr_vec = (wr_iclr ? wd_irq : '0) | (rd_masked ? masked : '0);
    // a new event wins over a clear in the same cycle
    wire [NIRQ-1:0] next_raw = (raw & ~clr_vec) | set_vec;
    wire [NIRQ-1:0] next_ien = wr_ien_set ? (ien | wd_irq) :
        wr_ien_clr ? (ien & ~wd_irq) : ien;

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            raw <= '0;
            ien <= '0;
            irq <= 1'b0;
        end
        else
        begin
            raw <= next_raw;
            ien <= next_ien;
            irq <= |masked;
        end
    end

    //------------------------------------------------------------------
    // configuration
    //------------------------------------------------------------------
    // out-of-range codes are ignored so the fields always hold a legal setting
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_thr <= THR_RESET;
            rx_thr <= THR_RESET;
            par_mode <= parity_off;
        end
        else
        begin
            if (wr_thr && wd_tx_thr <= THR_MAX)
                tx_thr <= wd_tx_thr;
            if (wr_thr && wd_rx_thr <= THR_MAX)
                rx_thr <= wd_rx_thr;
            if (wr_par && wd[PAR_W-1:0] <= PAR_MAX)
                par_mode <= wd[PAR_W-1:0];
        end
    end

    //------------------------------------------------------------------
    // transmit stage and level history
    //------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_valid <= 1'b0;
            tx_char <= '0;
            tx_par <= 1'b0;
            tx_par_en <= 1'b0;
            tx_lvl_q <= '0;
            rx_lvl_q <= '0;
        end
        else
        begin
            tx_par_en <= par_en;
            tx_lvl_q <= txf.level;
            rx_lvl_q <= rxf.level;
            if (tx_pop)
            begin
                tx_valid <= 1'b1;
                tx_char <= txf.rdata;
                tx_par <= tx_par_bit;
            end
            else if (tx_ready)
                tx_valid <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // axi4-lite slave
    //------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_addr <= '0;
            wd <= '0;
            lane0 <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wd <= s_axi_wdata;
                lane0 <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_wr)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    a_tx_thresh_irq: assert property (tx_cross |=> raw[irq_transmit])
        else $error("tx threshold crossing did not set status");
    a_rx_thresh_irq: assert property (rx_cross |=> raw[irq_receive])
        else $error("rx threshold crossing did not set status");
    a_thresh_readback: assert property (rd_fire && s_axi_araddr == REG_THRESH
        |=> s_axi_rvalid && s_axi_rdata[THR_RX_LSB+THR_W-1:0] == {$past(rx_thr), $past(tx_thr)})
        else $error("threshold read back wrong");
    a_overrun_status: assert property (rx_valid && rxf.full |=> raw[irq_overrun])
        else $error("overrun not flagged");
    a_enable_others_kept: assert property (wr_ien_set || wr_ien_clr
        |=> (ien & ~$past(wd_irq)) == ($past(ien) & ~$past(wd_irq)))
        else $error("unselected enable bits changed");
    a_irq_masked_only: assert property (##1 irq == |$past(masked))
        else $error("interrupt output not equal to masked status");
    a_clear_mask_drop: assert property (wr_iclr
        |=> (raw & $past(wd_irq) & ~$past(set_vec)) == '0)
        else $error("cleared status bit still set");
    a_masked_view: assert property (rd_masked
        |=> s_axi_rdata == DW'($past(masked)))
        else $error("masked view differs from raw and enable");
    a_forced_high_bit: assert property (tx_pop && par_mode == parity_forced_high
        |=> tx_valid && tx_par)
        else $error("forced high parity not sent as one");
    a_parity_check: assert property (rx_valid && par_mode != parity_off
        && rx_par != uic_par_bit(par_mode, rx_char) |=> raw[irq_parity_error])
        else $error("parity mismatch not flagged");
    a_parity_readback: assert property (rd_fire && s_axi_araddr == REG_PARITY
        |=> s_axi_rdata == DW'($past(par_mode)))
        else $error("parity mode read back wrong");
    a_space_flag: assert property (rd_fire && s_axi_araddr == REG_FLAGS
        |=> s_axi_rdata[FLAG_TX_SPACE] == !$past(txf.full))
        else $error("tx space flag wrong");
    a_avail_flag: assert property (rd_fire && s_axi_araddr == REG_FLAGS
        |=> s_axi_rdata[FLAG_RX_AVAIL] == !$past(rxf.empty))
        else $error("rx data flag wrong");
    a_status_sticky: assert property (##1 ($past(raw) & ~$past(clr_vec) & ~raw) == '0)
        else $error("status bit dropped without a clear");

    c_irq_rise: cover property (!irq ##1 irq);
    c_overrun: cover property (overrun);
    c_tx_cross: cover property (tx_cross && ien[irq_transmit]);
    c_masked_ack: cover property (rd_masked && masked != '0);
endmodule

/* inc/uic_pkg.sv */
// uic_pkg: register map, codes and helpers of the uart irq, fifo threshold and parity slice
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package uic_pkg;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int CW = 8;
    localparam int NIRQ = 7;
    localparam int FIFO_DEPTH = 16;
    localparam int THR_W = 3;
    localparam int PAR_W = 3;
    localparam int THR_RX_LSB = 3;
    localparam int FLAG_TX_SPACE = 0;
    localparam int FLAG_RX_AVAIL = 1;
    //------------------------------------------------------------------
    // register byte offsets
    //------------------------------------------------------------------
    localparam logic [AW-1:0] REG_DATA = 8'h00;
    localparam logic [AW-1:0] REG_FLAGS = 8'h04;
    localparam logic [AW-1:0] REG_THRESH = 8'h08;
    localparam logic [AW-1:0] REG_PARITY = 8'h0C;
    localparam logic [AW-1:0] REG_IEN_SET = 8'h10;
    localparam logic [AW-1:0] REG_IEN_CLR = 8'h14;
    localparam logic [AW-1:0] REG_RAW = 8'h18;
    localparam logic [AW-1:0] REG_MASKED = 8'h1C;
    localparam logic [AW-1:0] REG_ICLR = 8'h20;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // interrupt bit positions
    localparam int irq_receive = 0;
    localparam int irq_transmit = 1;
    localparam int irq_receive_timeout = 2;
    localparam int irq_framing_error = 3;
    localparam int irq_parity_error = 4;
    localparam int irq_break_error = 5;
    localparam int irq_overrun = 6;
    typedef enum logic [PAR_W-1:0] {
        parity_off = 3'h0, parity_even_mode = 3'h1, parity_odd_mode = 3'h2,
        parity_forced_high = 3'h3, parity_forced_low = 3'h4
    } uic_parity_type;
    typedef enum logic [THR_W-1:0] {
        tx_thresh_one_eighth = 3'h0, tx_thresh_two_eighths = 3'h1,
        tx_thresh_four_eighths = 3'h2, tx_thresh_six_eighths = 3'h3,
        tx_thresh_seven_eighths = 3'h4
    } uic_tx_thresh_type;
    typedef enum logic [THR_W-1:0] {
        rx_thresh_one_eighth = 3'h0, rx_thresh_two_eighths = 3'h1,
        rx_thresh_four_eighths = 3'h2, rx_thresh_six_eighths = 3'h3,
        rx_thresh_seven_eighths = 3'h4
    } uic_rx_thresh_type;
    localparam logic [THR_W-1:0] THR_RESET = 3'h2;
    localparam logic [THR_W-1:0] THR_MAX = 3'h4;
    localparam logic [PAR_W-1:0] PAR_MAX = 3'h4;

    // parity bit for a character under a given mode
    function automatic logic uic_par_bit(input logic [PAR_W-1:0] m, input logic [CW-1:0] d);
        case (m)
            parity_odd_mode: return ~^d;
            parity_forced_high: return 1'b1;
            parity_forced_low: return 1'b0;
            default: return ^d;
        endcase
    endfunction
endpackage

/* inc/uic_fifo_if.sv */
// uic_fifo_if: push, pop and level signals between the slice and one character fifo
`timescale 1ns/1ps
interface uic_fifo_if #(parameter int W = 8, parameter int LW = 5);
    logic push;
    logic pop;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    logic [LW-1:0] level;
    logic full;
    logic empty;
    modport owner (input push, pop, wdata, output rdata, level, full, empty);
    modport user (output push, pop, wdata, input rdata, level, full, empty);
endinterface

/* hdl/uic_fifo.sv */
// uic_fifo: flip-flop character fifo with fill level
`timescale 1ns/1ps
module uic_fifo
#(
    parameter int W = 8,
    parameter int DEPTH = 16,
    parameter int LW = 5
)
(
    // clock and reset
    input logic clk,
    input logic rst,
    // fifo port
    uic_fifo_if.owner f
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [LW-1:0] cnt;
    // push on a full fifo and pop on an empty one are dropped
    wire do_push = f.push && !f.full;
    wire do_pop = f.pop && !f.empty;
    assign f.rdata = mem[rp];
    assign f.level = cnt;
    assign f.full = (cnt == LW'(DEPTH));
    assign f.empty = (cnt == '0);
    always_ff @(posedge clk)
    begin
        if (do_push)
            mem[wp] <= f.wdata;
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end
        else
        begin
            if (do_push)
                wp <= PW'(wp + 1'b1);
            if (do_pop)
                rp <= PW'(rp + 1'b1);
            cnt <= LW'(cnt + LW'(do_push) - LW'(do_pop));
        end
    end
endmodule

/* hdl/uic_parity.sv */
// uic_parity: parity generation for transmit and checking for receive
`timescale 1ns/1ps
module uic_parity
    import uic_pkg::*;
(
    // mode
    input logic [PAR_W-1:0] mode,
    // transmit side
    input logic [CW-1:0] tx_data,
    output logic tx_bit,
    output logic par_en,
    // receive side
    input logic [CW-1:0] rx_data,
    input logic rx_bit,
    output logic rx_err
);
    assign par_en = (mode != parity_off);
    // forced modes use the same constant for both directions
    assign tx_bit = uic_par_bit(mode, tx_data);
    assign rx_err = par_en && (rx_bit != uic_par_bit(mode, rx_data));
endmodule

/* tb/uic_line_model.sv */
// uic_line_model: serializer and deserializer stand-in on the line side
`timescale 1ns/1ps
module uic_line_model
    import uic_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // characters from the slice
    input wire logic [CW-1:0] tx_char,
    input wire logic tx_par,
    input wire logic tx_par_en,
    input wire logic tx_valid,
    output logic tx_ready,
    // characters and events to the slice
    output logic rx_valid,
    output logic [CW-1:0] rx_char,
    output logic rx_par,
    output logic rx_break,
    output logic rx_frame_err,
    output logic rx_timeout
);
    logic stall = 1'b0;
    logic [2:0] ev = 3'h0;
    logic [CW+1:0] got[$];
    assign {rx_break, rx_frame_err, rx_timeout} = ev;
    initial
    begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_char = 8'hA5;
        rx_par = 1'b0;
    end
    // stall lets the bench fill the transmit side until it refuses
    always @(posedge sys_clk)
    begin
        if (tx_valid && tx_ready)
            got.push_back({tx_par_en, tx_par, tx_char});
        tx_ready <= !stall;
    end
    // idle data lines show the inverse so stale values never match
    task automatic send(input logic [CW-1:0] c, input logic p);
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        rx_char <= c;
        rx_par <= p;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_char <= ~c;
        rx_par <= ~p;
    endtask
    task automatic pulse(input logic [2:0] k);
        @(posedge sys_clk);
        ev <= k;
        @(posedge sys_clk);
        ev <= 3'h0;
    endtask
endmodule

/* tb/tb_top.sv */
// tb_top: self-checking bench for the uart irq, threshold and parity slice
`timescale 1ns/1ps
module tb_top
    import uic_pkg::*;
;
    logic sys_clk, sys_rst;
    logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DW-1:0] s_axi_wdata, s_axi_rdata, rd_q;
    logic [3:0] s_axi_wstrb, strb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [CW-1:0] tx_char, rx_char;
    logic tx_par, tx_par_en, tx_valid, tx_ready, rx_valid, rx_par;
    logic rx_break, rx_frame_err, rx_timeout, irq;
    int errors = 0;
    int checks = 0;
    uic_top #(.DEPTH(16)) uut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .tx_char, .tx_par, .tx_par_en, .tx_valid, .tx_ready, .rx_valid, .rx_char,
        .rx_par, .rx_break, .rx_frame_err, .rx_timeout, .irq);
    uic_line_model line (.sys_clk, .tx_char, .tx_par, .tx_par_en, .tx_valid, .tx_ready,
        .rx_valid, .rx_char, .rx_par, .rx_break, .rx_frame_err, .rx_timeout);
    //----------------------------------------------------------------------
    // bus tasks and compare
    //----------------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] p;
        @(posedge sys_clk);
        p = 2'h3;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            p = p & ~{s_axi_wready, s_axi_awready};
            s_axi_awvalid <= p[0];
            s_axi_wvalid <= p[1];
        end while (p != 2'h0);
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        resp_q = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        rd_q = s_axi_rdata;
        resp_q = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(n, e, rd_q);
    endtask
    function automatic logic ep(input int m, input logic [7:0] d);
        return (m == 2) ? ~^d : (m == 3) ? 1'b1 : (m == 4) ? 1'b0 : ^d;
    endfunction
    //----------------------------------------------------------------------
    // scenarios
    //----------------------------------------------------------------------
    task automatic t_reset();
        rdc("thresh", REG_THRESH, 32'h12);
        rdc("parity", REG_PARITY, 32'h0);
        rdc("flags", REG_FLAGS, 32'h1);
        rdc("raw", REG_RAW, 32'h0);
        strb = 4'h0;
        wr(REG_THRESH, 32'h0);
        chk("bresp", 32'(RESP_OKAY), 32'(resp_q));
        strb = 4'hF;
        rdc("thresh", REG_THRESH, 32'h12);
        chk("rresp", 32'(RESP_OKAY), 32'(resp_q));
        // code 5 is not a threshold and must leave the fields alone
        for (int i = 0; i < 6; i++)
        begin
            wr(REG_THRESH, 32'(i * 9));
            rdc("thresh", REG_THRESH, 32'((i < 5 ? i : 4) * 9));
        end
        // the clear mask is write-only, so a read of it is refused
        rdc("unmapped", REG_ICLR, 32'h0);
        chk("rresp", 32'(RESP_SLVERR), 32'(resp_q));
        wr(8'h40, 32'h0);
        chk("bresp", 32'(RESP_SLVERR), 32'(resp_q));
    endtask
    task automatic t_parity();
        for (int m = 0; m < 6; m++)
        begin
            wr(REG_PARITY, 32'(m));
            rdc("parity", REG_PARITY, 32'(m < 5 ? m : 4));
            if (m == 5)
                break;
            wr(REG_DATA, 32'h34);
            while (line.got.size() == 0) @(posedge sys_clk);
            chk("tx beat", {m != 0, ep(m, 8'h34), 8'h34}, line.got.pop_front());
            line.send(8'hC4, ~ep(m, 8'hC4));
            line.send(8'h34, ep(m, 8'h34));
            rdc("raw parity", REG_RAW, 32'(m != 0) << 4);
            wr(REG_ICLR, 32'h10);
            rdc("rx char", REG_DATA, 32'hC4);
            rd(REG_DATA);
        end
        rdc("raw", REG_RAW, 32'h0);
    endtask
    task automatic t_irq();
        wr(REG_IEN_SET, 32'h28);
        wr(REG_IEN_SET, 32'h01);
        wr(REG_IEN_CLR, 32'h09);
        rdc("enable", REG_IEN_SET, 32'h20);
        line.pulse(3'h7);
        rdc("raw", REG_RAW, 32'h2C);
        chk("irq", 32'h1, 32'(irq));
        rdc("masked", REG_MASKED, 32'h20);
        rdc("raw", REG_RAW, 32'h0C);
        chk("irq", 32'h0, 32'(irq));
        wr(REG_ICLR, 32'h04);
        rdc("raw", REG_RAW, 32'h08);
        wr(REG_ICLR, 32'h7F);
    endtask
    task automatic t_rx();
        wr(REG_THRESH, 32'h0);
        wr(REG_IEN_SET, 32'h41);
        line.send(8'h00, 1'b0);
        rdc("raw", REG_RAW, 32'h0);
        rdc("flags", REG_FLAGS, 32'h3);
        for (int i = 1; i < 17; i++)
            line.send(8'(i), 1'b0);
        rdc("raw", REG_RAW, 32'h41);
        chk("irq", 32'h1, 32'(irq));
        for (int i = 0; i < 16; i++)
            rdc("rx char", REG_DATA, 32'(i));
        rdc("flags", REG_FLAGS, 32'h1);
        wr(REG_ICLR, 32'h7F);
    endtask
    task automatic t_tx();
        line.stall <= 1'b1;
        for (int i = 0; i < 20; i++)
            wr(REG_DATA, 32'(8'h80 + i));
        rdc("flags", REG_FLAGS, 32'h0);
        rdc("raw", REG_RAW, 32'h0);
        line.stall <= 1'b0;
        while (line.got.size() < 16) @(posedge sys_clk);
        rdc("raw", REG_RAW, 32'h2);
        rdc("flags", REG_FLAGS, 32'h1);
        chk("tx order", 32'h280, 32'(line.got.pop_front()));
        chk("tx order", 32'h281, 32'(line.got.pop_front()));
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    //----------------------------------------------------------------------
    // clock, reset, sequence and watchdog
    //----------------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial
    begin
        sys_rst = 1'b1;
        strb = 4'hF;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_parity();
        t_irq();
        t_rx();
        t_tx();
        give_verdict();
    end
    // whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        give_verdict();
    end
endmodule
